// >>> src/qdp_pkg.sv
`default_nettype none
package qdp_pkg;
  // Widths of the pointer, data bus and register index
  localparam int PTR_W   = 11;
  localparam int DATA_W  = 32;
  localparam int ADDR_W  = 8;
  localparam int IDX_W   = 6;
  localparam int IDX_LSB = 2;
  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_TX_CMD  = 6'h00;
  localparam logic [IDX_W-1:0] IDX_RX_CMD  = 6'h02;
  localparam logic [IDX_W-1:0] IDX_TX_PTR  = 6'h04;
  localparam logic [IDX_W-1:0] IDX_RX_PTR  = 6'h06;
  localparam logic [IDX_W-1:0] IDX_DATA_LO = 6'h08;
  localparam logic [IDX_W-1:0] IDX_DATA_HI = 6'h0A;
  // Read windows with a fixed access size
  localparam logic [IDX_W-1:0] IDX_RD_BYTE  = 6'h10;
  localparam logic [IDX_W-1:0] IDX_RD_WORD  = 6'h11;
  localparam logic [IDX_W-1:0] IDX_RD_DWORD = 6'h12;
  // Field positions
  localparam int AUTO_BIT = 14;
  localparam int CMD_BIT  = 0;
  // Access sizes in bytes
  localparam logic [2:0] SZ_NONE  = 3'h0;
  localparam logic [2:0] SZ_BYTE  = 3'h1;
  localparam logic [2:0] SZ_WORD  = 3'h2;
  localparam logic [2:0] SZ_DWORD = 3'h4;
  // Reset values
  localparam logic [PTR_W-1:0]  PTR_RST   = 11'h000;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

  // One word bound for the transmit queue
  typedef struct packed {
    logic [PTR_W-1:0]  addr;   // Byte location in the transmit queue
    logic [3:0]        strb;   // Bytes valid, from lane zero upward
    logic [DATA_W-1:0] data;   // Data, first byte in the low lane
  } qdp_txw_t;

  // Whole state of the access block
  typedef struct packed {
    logic [PTR_W-1:0]  rx_ptr;   // Receive pointer field
    logic              rx_auto;  // Receive auto advance
    logic [PTR_W-1:0]  tx_ptr;   // Transmit pointer field
    logic              tx_auto;  // Transmit auto advance
    logic              rx_rel;   // Release command pending
    logic              tx_enq;   // Enqueue command pending
    logic              ready;    // APB ready
    logic              err;      // APB slave error
    logic [DATA_W-1:0] rdata;    // APB read data
  } qdp_state_t;

  // Number of enabled byte lanes
  function automatic logic [2:0] qdp_strb_size(input logic [3:0] s);
    qdp_strb_size = 3'(s[0]) + 3'(s[1]) + 3'(s[2]) + 3'(s[3]);
  endfunction

  // Lowest enabled byte lane
  function automatic logic [1:0] qdp_first_lane(input logic [3:0] s);
    if (s[0]) begin
      qdp_first_lane = 2'h0;
    end else if (s[1]) begin
      qdp_first_lane = 2'h1;
    end else if (s[2]) begin
      qdp_first_lane = 2'h2;
    end else begin
      qdp_first_lane = 2'h3;
    end
  endfunction

  // Lane mask for an access size
  function automatic logic [3:0] qdp_size_mask(input logic [2:0] sz);
    unique case (sz)
      SZ_BYTE: qdp_size_mask = 4'h1;
      SZ_WORD: qdp_size_mask = 4'h3;
      SZ_DWORD: qdp_size_mask = 4'hF;
      default: qdp_size_mask = 4'h0;
    endcase
  endfunction
endpackage
`default_nettype wire

// >>> src/qdp_rxq_mem.sv
`timescale 1ns/1ps
`default_nettype none
// Receive queue byte memory: filled by the queue manager, read by the host
module qdp_rxq_mem #(
  parameter int AW    = 11,
  parameter int DEPTH = 2048
) (
  input  wire logic          clk,         // System clock
  input  wire logic          fill_valid,  // Queue manager writes one byte
  input  wire logic [AW-1:0] fill_addr,   // Byte location written
  input  wire logic [7:0]    fill_data,   // Byte written
  input  wire logic [AW-1:0] rd_addr,     // First byte of the host read
  output logic      [31:0]   rd_data      // Four bytes from rd_addr upward
);
  // Byte array, no reset on purpose
  logic [7:0] mem [DEPTH];

  // Fill port
  always_ff @(posedge clk) begin
    if (fill_valid) begin
      mem[fill_addr] <= fill_data;
    end
  end

  // Unaligned read, locations wrap around the pointer range
  always_comb begin
    rd_data = {mem[AW'(rd_addr + AW'(3))], mem[AW'(rd_addr + AW'(2))],
               mem[AW'(rd_addr + AW'(1))], mem[rd_addr]};
  end
endmodule // qdp_rxq_mem
`default_nettype wire

// >>> src/qdp_buf.sv
`timescale 1ns/1ps
`default_nettype none
// Small FIFO between the host writes and the transmit queue
module qdp_buf #(
  parameter int W     = 47,
  parameter int DEPTH = 2
) (
  input  wire logic         pclk,      // System clock
  input  wire logic         presetn,   // Async reset, active low
  input  wire logic         in_valid,  // Word offered
  output logic              in_ready,  // Room for a word
  input  wire logic [W-1:0] in_data,   // Word in
  output logic              out_valid, // Word held
  input  wire logic         out_ready, // Drain side takes it
  output logic      [W-1:0] out_data   // Oldest word
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] CNT_FULL = (PW+1)'(DEPTH);

  // Entries, pointers and fill count
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] ent;
    logic [PW-1:0]           rd;
    logic [PW-1:0]           wr;
    logic [PW:0]             cnt;
  } qdp_buf_st_t;

  qdp_buf_st_t s_q;
  qdp_buf_st_t s_d;
  logic        push;
  logic        pop;

  // Honest full and empty straight from the count
  always_comb begin
    in_ready  = (s_q.cnt != CNT_FULL);
    out_valid = (s_q.cnt != '0);
    out_data  = s_q.ent[s_q.rd];
  end

  // Pointer and count update
  always_comb begin
    s_d  = s_q;
    push = in_valid && in_ready;
    pop  = out_valid && out_ready;
    if (push) begin
      s_d.ent[s_q.wr] = in_data;
      s_d.wr = (s_q.wr == PW'(DEPTH - 1)) ? '0 : PW'(s_q.wr + 1'b1);
    end
    if (pop) begin
      s_d.rd = (s_q.rd == PW'(DEPTH - 1)) ? '0 : PW'(s_q.rd + 1'b1);
    end
    if (push && !pop) begin
      s_d.cnt = (PW+1)'(s_q.cnt + 1'b1);
    end else if (pop && !push) begin
      s_d.cnt = (PW+1)'(s_q.cnt - 1'b1);
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule // qdp_buf
`default_nettype wire

// >>> src/qdp_top.sv
// Behaviour
// - Receive auto advance on data window reads
// - Advance by one, two or four bytes
// - Manual mode: pointer only moves by writes and release reloads
// - Receive pointer: 11-bit field, resets zero
// - Release completion reloads next receive frame
// - Reads from receive queue, writes to transmit
// - Any pointer alignment transfers correctly
// - Byte, word, dword accesses mix freely
// - Data words pair per bus width
// - Transmit auto advance on data writes
// - Release bit self clears after freeing
// - Enqueue completion reloads next transmit frame
`timescale 1ns/1ps
`default_nettype none
module qdp_top #(
  parameter bit BUS32     = 1'b1,  // 1: 32-bit host bus, 0: 16-bit host bus
  parameter int RXQ_DEPTH = 2048,  // Receive queue bytes
  parameter int BUF_DEPTH = 2      // Transmit path buffer entries
) (
  input  wire logic                      pclk,            // System clock
  input  wire logic                      presetn,         // Async reset, active low
  input  wire logic [qdp_pkg::ADDR_W-1:0] paddr,          // APB address
  input  wire logic                      psel,            // APB select
  input  wire logic                      penable,         // APB enable
  input  wire logic                      pwrite,          // APB direction
  input  wire logic [qdp_pkg::DATA_W-1:0] pwdata,         // APB write data
  input  wire logic [3:0]                pstrb,           // APB byte strobes
  output logic                           pready,          // APB ready
  output logic      [qdp_pkg::DATA_W-1:0] prdata,         // APB read data
  output logic                           pslverr,         // APB error
  input  wire logic                      rxq_fill_valid,  // Queue manager fills a byte
  input  wire logic [qdp_pkg::PTR_W-1:0] rxq_fill_addr,   // Fill location
  input  wire logic [7:0]                rxq_fill_data,   // Fill byte
  output logic                           rx_release_req,  // Release command pending
  input  wire logic                      rx_release_done, // Frame memory freed
  input  wire logic [qdp_pkg::PTR_W-1:0] rx_next_frame,   // Next receive frame location
  output logic                           tx_enqueue_req,  // Enqueue command pending
  input  wire logic                      tx_enqueue_done, // Frame taken for transmit
  input  wire logic [qdp_pkg::PTR_W-1:0] tx_next_frame,   // Next transmit frame location
  output logic                           txq_wr_valid,    // Word for the transmit queue
  input  wire logic                      txq_wr_ready,    // Transmit queue takes it
  output qdp_pkg::qdp_txw_t              txq_wr_word      // Word with location and lanes
);
  localparam int TXW_W = $bits(qdp_pkg::qdp_txw_t);

  qdp_pkg::qdp_state_t s_q;           // Registered state
  qdp_pkg::qdp_state_t s_d;           // Next state
  logic [qdp_pkg::IDX_W-1:0] idx;     // Register index of the access
  logic                      done;    // Access completes at this edge
  logic                      mapped;  // Index names a register
  logic                      is_data; // Low or high data word
  logic                      is_rdwin;// Any window that reads the queue
  logic [2:0]                rsz;     // Size of a queue read
  logic [2:0]                wsz;     // Size of a queue write
  logic [31:0]               rxq_rd;  // Four bytes at the receive pointer
  logic [31:0]               rd_fmt;  // Queue read value, sized
  logic [31:0]               rd_val;  // Read value of the addressed register
  logic                      buf_in_ready; // Room in the transmit buffer
  logic                      tx_push; // Write pushed to the transmit buffer
  qdp_pkg::qdp_txw_t         tx_word; // Word pushed
  logic [TXW_W-1:0]          buf_out; // Buffer output bits
  logic [qdp_pkg::PTR_W-1:0] rx_adv;  // Receive pointer after a read
  logic [qdp_pkg::PTR_W-1:0] tx_adv;  // Transmit pointer after a write

  // Read size by window; low word is a dword only on a 32-bit bus
  function automatic logic [2:0] read_size(input logic [qdp_pkg::IDX_W-1:0] i);
    unique case (i)
      qdp_pkg::IDX_DATA_LO: read_size = BUS32 ? qdp_pkg::SZ_DWORD : qdp_pkg::SZ_WORD;
      qdp_pkg::IDX_DATA_HI: read_size = qdp_pkg::SZ_WORD;
      qdp_pkg::IDX_RD_BYTE: read_size = qdp_pkg::SZ_BYTE;
      qdp_pkg::IDX_RD_WORD: read_size = qdp_pkg::SZ_WORD;
      qdp_pkg::IDX_RD_DWORD: read_size = qdp_pkg::SZ_DWORD;
      default: read_size = qdp_pkg::SZ_NONE;
    endcase
  endfunction

  // Pointer register image, reserved bits zero
  function automatic logic [31:0] ptr_image(input logic a, input logic [10:0] p);
    ptr_image = {16'h0000, 1'b0, a, 3'h0, p};
  endfunction

  // Receive queue memory
  qdp_rxq_mem #(
    .AW    (qdp_pkg::PTR_W),
    .DEPTH (RXQ_DEPTH)
  ) u_rxq (
    .clk        (pclk),
    .fill_valid (rxq_fill_valid),
    .fill_addr  (rxq_fill_addr),
    .fill_data  (rxq_fill_data),
    .rd_addr    (s_q.rx_ptr),
    .rd_data    (rxq_rd)
  );

  // Buffer toward the transmit queue; a full buffer stalls the APB write
  qdp_buf #(
    .W     (TXW_W),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (tx_push),
    .in_ready  (buf_in_ready),
    .in_data   (tx_word),
    .out_valid (txq_wr_valid),
    .out_ready (txq_wr_ready),
    .out_data  (buf_out)
  );

  // Buffer bits back into the carrier struct
  always_comb begin
    txq_wr_word = qdp_pkg::qdp_txw_t'(buf_out);
  end

  // Address decode and access sizes
  always_comb begin
    idx      = paddr[qdp_pkg::ADDR_W-1:qdp_pkg::IDX_LSB];
    done     = psel && penable && s_q.ready;
    is_data  = (idx == qdp_pkg::IDX_DATA_LO) || (idx == qdp_pkg::IDX_DATA_HI);
    rsz      = read_size(idx);
    is_rdwin = (rsz != qdp_pkg::SZ_NONE);
    mapped   = is_rdwin || (idx == qdp_pkg::IDX_TX_CMD) || (idx == qdp_pkg::IDX_RX_CMD)
            || (idx == qdp_pkg::IDX_TX_PTR) || (idx == qdp_pkg::IDX_RX_PTR);
    wsz      = qdp_pkg::qdp_strb_size(pstrb);
  end

  // Receive read shaping: bytes from the pointer, any alignment
  always_comb begin
    unique case (rsz)
      qdp_pkg::SZ_BYTE: rd_fmt = {24'h000000, rxq_rd[7:0]};
      qdp_pkg::SZ_WORD: rd_fmt = {16'h0000, rxq_rd[15:0]};
      qdp_pkg::SZ_DWORD: rd_fmt = rxq_rd;
      default: rd_fmt = 32'h0000_0000;
    endcase
  end

  // Register read mux
  always_comb begin
    if (is_rdwin) begin
      rd_val = rd_fmt;
    end else if (idx == qdp_pkg::IDX_RX_PTR) begin
      rd_val = ptr_image(s_q.rx_auto, s_q.rx_ptr);
    end else if (idx == qdp_pkg::IDX_TX_PTR) begin
      rd_val = ptr_image(s_q.tx_auto, s_q.tx_ptr);
    end else if (idx == qdp_pkg::IDX_RX_CMD) begin
      rd_val = {31'h0000_0000, s_q.rx_rel};
    end else if (idx == qdp_pkg::IDX_TX_CMD) begin
      rd_val = {31'h0000_0000, s_q.tx_enq};
    end else begin
      rd_val = 32'h0000_0000;
    end
  end

  // Transmit word: data moved down to lane zero, lanes from the size
  always_comb begin
    tx_push      = done && pwrite && is_data && (pstrb != 4'h0);
    tx_word.addr = s_q.tx_ptr;
    tx_word.strb = qdp_pkg::qdp_size_mask(wsz);
    tx_word.data = pwdata >> {qdp_pkg::qdp_first_lane(pstrb), 3'h0};
    rx_adv       = qdp_pkg::PTR_W'(s_q.rx_ptr + qdp_pkg::PTR_W'(rsz));
    tx_adv       = qdp_pkg::PTR_W'(s_q.tx_ptr + qdp_pkg::PTR_W'(wsz));
  end

  // Next state
  always_comb begin
    s_d = s_q;
    // APB: ready one cycle after select, held off on data writes while the buffer is full
    s_d.ready = psel && !s_q.ready && (!(pwrite && is_data) || buf_in_ready);
    s_d.err   = psel && !s_q.ready && !mapped;
    if (psel && !s_q.ready) begin
      s_d.rdata = pwrite ? qdp_pkg::RDATA_RST : rd_val;
    end
    // Receive pointer: reload, then register write, then advance
    if (rx_release_done) begin
      s_d.rx_ptr = rx_next_frame;
    end else if (done && pwrite && (idx == qdp_pkg::IDX_RX_PTR)) begin
      s_d.rx_ptr = pwdata[qdp_pkg::PTR_W-1:0];
    end else if (done && !pwrite && is_rdwin && s_q.rx_auto) begin
      s_d.rx_ptr = rx_adv;
    end
    if (done && pwrite && (idx == qdp_pkg::IDX_RX_PTR)) begin
      s_d.rx_auto = pwdata[qdp_pkg::AUTO_BIT];
    end
    // Transmit pointer: reload, then register write, then advance
    if (tx_enqueue_done) begin
      s_d.tx_ptr = tx_next_frame;
    end else if (done && pwrite && (idx == qdp_pkg::IDX_TX_PTR)) begin
      s_d.tx_ptr = pwdata[qdp_pkg::PTR_W-1:0];
    end else if (tx_push && s_q.tx_auto) begin
      s_d.tx_ptr = tx_adv;
    end
    if (done && pwrite && (idx == qdp_pkg::IDX_TX_PTR)) begin
      s_d.tx_auto = pwdata[qdp_pkg::AUTO_BIT];
    end
    // Command bits: hardware clears, a new software set wins
    if (rx_release_done) begin
      s_d.rx_rel = 1'b0;
    end
    if (done && pwrite && (idx == qdp_pkg::IDX_RX_CMD) && pwdata[qdp_pkg::CMD_BIT]) begin
      s_d.rx_rel = 1'b1;
    end
    if (tx_enqueue_done) begin
      s_d.tx_enq = 1'b0;
    end
    if (done && pwrite && (idx == qdp_pkg::IDX_TX_CMD) && pwdata[qdp_pkg::CMD_BIT]) begin
      s_d.tx_enq = 1'b1;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q.rx_ptr  <= qdp_pkg::PTR_RST;
      s_q.rx_auto <= 1'b0;
      s_q.tx_ptr  <= qdp_pkg::PTR_RST;
      s_q.tx_auto <= 1'b0;
      s_q.rx_rel  <= 1'b0;
      s_q.tx_enq  <= 1'b0;
      s_q.ready   <= 1'b0;
      s_q.err     <= 1'b0;
      s_q.rdata   <= qdp_pkg::RDATA_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state
  always_comb begin
    pready         = s_q.ready;
    pslverr        = s_q.err;
    prdata         = s_q.rdata;
    rx_release_req = s_q.rx_rel;
    tx_enqueue_req = s_q.tx_enq;
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Receive pointer movement
  a_rx_auto_step: assert property (
    done && !pwrite && is_rdwin && s_q.rx_auto && !rx_release_done
    |=> s_q.rx_ptr == $past(rx_adv))
    else $error("receive pointer did not advance by access size");

  a_rx_size_dword: assert property (
    done && !pwrite && (idx == qdp_pkg::IDX_RD_DWORD) && s_q.rx_auto && !rx_release_done
    |=> s_q.rx_ptr == qdp_pkg::PTR_W'($past(s_q.rx_ptr) + 11'h004))
    else $error("dword read did not advance pointer by four");

  a_rx_manual_hold: assert property (
    done && !pwrite && is_rdwin && !s_q.rx_auto && !rx_release_done
    |=> $stable(s_q.rx_ptr))
    else $error("receive pointer moved in manual mode");

  a_rx_ptr_write: assert property (
    done && pwrite && (idx == qdp_pkg::IDX_RX_PTR) && !rx_release_done
    |=> s_q.rx_ptr == $past(pwdata[qdp_pkg::PTR_W-1:0]))
    else $error("receive pointer write not taken");

  a_rx_auto_write: assert property (
    done && pwrite && (idx == qdp_pkg::IDX_RX_PTR)
    |=> s_q.rx_auto == $past(pwdata[qdp_pkg::AUTO_BIT]))
    else $error("auto advance write not taken");

  a_rx_reload: assert property (
    rx_release_done |=> s_q.rx_ptr == $past(rx_next_frame))
    else $error("receive pointer not reloaded on release");

  // Data window direction and shaping
  a_tx_write_path: assert property (
    tx_push |-> buf_in_ready ##1 txq_wr_valid)
    else $error("data window write lost");

  a_wr_rx_still: assert property (
    done && pwrite && is_data && !rx_release_done |=> $stable(s_q.rx_ptr))
    else $error("data write moved receive pointer");

  a_rd_tx_still: assert property (
    done && !pwrite && is_rdwin && !tx_enqueue_done |=> $stable(s_q.tx_ptr))
    else $error("data read moved transmit pointer");

  a_byte_read_zero: assert property (
    psel && !s_q.ready && !pwrite && (idx == qdp_pkg::IDX_RD_BYTE)
    |=> s_q.rdata[31:8] == 24'h000000 && s_q.rdata[7:0] == $past(rxq_rd[7:0]))
    else $error("byte read value wrong");

  a_word_read_zero: assert property (
    psel && !s_q.ready && !pwrite && (idx == qdp_pkg::IDX_RD_WORD)
    |=> s_q.rdata[31:16] == 16'h0000 && s_q.rdata[15:0] == $past(rxq_rd[15:0]))
    else $error("word read value wrong");

  a_high_word_size: assert property (
    psel && !s_q.ready && !pwrite && (idx == qdp_pkg::IDX_DATA_HI)
    |=> s_q.rdata[31:16] == 16'h0000)
    else $error("high data word too wide");

  // Transmit pointer and commands
  a_tx_auto_step: assert property (
    tx_push && s_q.tx_auto && !tx_enqueue_done |=> s_q.tx_ptr == $past(tx_adv))
    else $error("transmit pointer did not advance");

  a_rel_set: assert property (
    done && pwrite && (idx == qdp_pkg::IDX_RX_CMD) && pwdata[qdp_pkg::CMD_BIT]
    |=> rx_release_req)
    else $error("release command not set");

  a_rel_self_clear: assert property (
    s_q.rx_rel && rx_release_done && !(done && pwrite && (idx == qdp_pkg::IDX_RX_CMD))
    |=> !rx_release_req)
    else $error("release bit did not clear");

  a_tx_reload: assert property (
    tx_enqueue_done |=> s_q.tx_ptr == $past(tx_next_frame))
    else $error("transmit pointer not reloaded on enqueue");

  a_enq_self_clear: assert property (
    s_q.tx_enq && tx_enqueue_done && !(done && pwrite && (idx == qdp_pkg::IDX_TX_CMD))
    |=> !tx_enqueue_req)
    else $error("enqueue bit did not clear");

  // Bus answers
  a_ptr_rsvd_zero: assert property (
    pready && !pwrite && (idx == qdp_pkg::IDX_RX_PTR)
    |-> prdata[31:15] == 17'h00000 && prdata[13:11] == 3'h0)
    else $error("reserved pointer bits not zero");

  a_err_unmapped: assert property (
    psel && !s_q.ready && !mapped |=> pready && pslverr)
    else $error("unmapped access not refused");

  a_ready_pulse: assert property (
    pready |=> !pready)
    else $error("ready held longer than one cycle");

  // Scenario covers
  c_auto_read: cover property (done && !pwrite && is_rdwin && s_q.rx_auto);
  c_tx_stall: cover property (psel && penable && !s_q.ready && !buf_in_ready);
  c_release: cover property (rx_release_req ##[1:20] rx_release_done);
  c_odd_word: cover property (done && !pwrite && (rsz == qdp_pkg::SZ_WORD) && s_q.rx_ptr[0]);
  c_ptr_wrap: cover property (done && !pwrite && s_q.rx_auto && (rx_adv < s_q.rx_ptr));
endmodule // qdp_top
`default_nettype wire

// >>> verif/qdp_qm_model.sv
`timescale 1ns/1ps
`default_nettype none
// Queue manager stand-in: loads the receive queue, answers commands, drains words
module qdp_qm_model #(
  parameter logic [10:0] RX_NEXT = 11'h123,  // Next receive frame location
  parameter logic [10:0] TX_NEXT = 11'h456   // Next transmit frame location
) (
  input  wire logic              pclk,            // System clock
  input  wire logic              presetn,         // Async reset, active low
  input  wire logic              stall,           // Hold the drain side off
  output logic                   fill_done,       // Receive queue loaded
  output logic                   rxq_fill_valid,  // Byte write strobe
  output logic      [10:0]       rxq_fill_addr,   // Byte location
  output logic      [7:0]        rxq_fill_data,   // Byte value
  input  wire logic              rx_release_req,  // Release pending
  output logic                   rx_release_done, // Frame freed
  output logic      [10:0]       rx_next_frame,   // Next receive frame
  input  wire logic              tx_enqueue_req,  // Enqueue pending
  output logic                   tx_enqueue_done, // Frame taken
  output logic      [10:0]       tx_next_frame,   // Next transmit frame
  input  wire logic              txq_wr_valid,    // Word offered
  output logic                   txq_wr_ready,    // Word taken
  input  wire qdp_pkg::qdp_txw_t txq_wr_word      // Offered word
);
  qdp_pkg::qdp_txw_t got[$];          // Words taken, oldest first
  int                rc[2] = '{0, 0}; // Answer delay per command
  int                seed = 24;       // Stall pattern stream
  assign rx_next_frame = RX_NEXT;
  assign tx_next_frame = TX_NEXT;
  // Load every byte with a known pattern after reset
  initial begin
    fill_done = 1'b0;
    rxq_fill_valid = 1'b0;
    rxq_fill_addr = 11'h000;
    rxq_fill_data = 8'h00;
    @(posedge presetn);
    for (int i = 0; i < 2048; i++) begin
      @(posedge pclk);
      rxq_fill_valid <= 1'b1;
      rxq_fill_addr <= 11'(i);
      rxq_fill_data <= 8'(i * 7 + 3);
    end
    @(posedge pclk);
    rxq_fill_valid <= 1'b0;
    rxq_fill_data <= 8'hA5;
    fill_done <= 1'b1;
  end
  // Done pulses a few cycles after a command; the drain stalls at random
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_release_done <= 1'b0;
      tx_enqueue_done <= 1'b0;
      txq_wr_ready <= 1'b0;
    end else begin
      rx_release_done <= (rc[0] == 1);
      tx_enqueue_done <= (rc[1] == 1);
      if (rc[0] != 0) rc[0] <= rc[0] - 1;
      else if (rx_release_req && !rx_release_done) rc[0] <= 4;
      if (rc[1] != 0) rc[1] <= rc[1] - 1;
      else if (tx_enqueue_req && !tx_enqueue_done) rc[1] <= 4;
      if (txq_wr_valid && txq_wr_ready) got.push_back(txq_wr_word);
      txq_wr_ready <= !stall && ($random(seed) & 1);
    end
  end
endmodule  // qdp_qm_model
`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, stall = 0;  // Bus and control
  logic [7:0]  paddr = 8'h00;         // Bus address
  logic [31:0] pwdata = 32'h0, rd, x; // Write data, read result, expected
  logic [3:0]  pstrb = 4'h0;          // Byte strobes
  logic pready, pslverr, er, fill_done, rxq_fill_valid, rx_release_req, rx_release_done;
  logic tx_enqueue_req, tx_enqueue_done, txq_wr_valid, txq_wr_ready;
  logic [31:0] prdata;                // Read data
  logic [7:0]  rxq_fill_data;         // Fill byte
  logic [10:0] rxq_fill_addr, rx_next_frame, tx_next_frame;
  qdp_pkg::qdp_txw_t txq_wr_word, g, w;  // Transmit words
  qdp_pkg::qdp_txw_t exp_q[$];         // Expected transmit words
  int n_errors = 0, checks = 0, seed = 24, rp, tp, au, i, e;
  logic [7:0] wa[5] = '{8'h40, 8'h44, 8'h48, 8'h20, 8'h28};  // Read windows
  int         ws[5] = '{1, 2, 4, 4, 2};                        // Their sizes
  logic [3:0] sm[3] = '{4'h1, 4'h3, 4'hF};                     // Write strobes
  always #50 pclk = ~pclk;  // 10 MHz
  qdp_top i_qdp_top (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
    .pready, .prdata, .pslverr, .rxq_fill_valid, .rxq_fill_addr, .rxq_fill_data,
    .rx_release_req, .rx_release_done, .rx_next_frame, .tx_enqueue_req, .tx_enqueue_done,
    .tx_next_frame, .txq_wr_valid, .txq_wr_ready, .txq_wr_word);
  qdp_qm_model i_qdp_qm_model (.pclk, .presetn, .stall, .fill_done, .rxq_fill_valid,
    .rxq_fill_addr, .rxq_fill_data, .rx_release_req, .rx_release_done, .rx_next_frame,
    .tx_enqueue_req, .tx_enqueue_done, .tx_next_frame, .txq_wr_valid, .txq_wr_ready,
    .txq_wr_word);
  // Compare and count
  task automatic chk(input logic [46:0] gv, input logic [46:0] ev);
    checks++;
    if (gv !== ev) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, gv, ev);
    end
  endtask
  // One APB transfer, waits for pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Counts and verdict
  task automatic report_and_stop;
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    wait (fill_done);
    apb(0, 8'h18, 0, 0);
    chk(rd, 0);
    apb(0, 8'hFC, 0, 0);
    chk(er, 1);
    // Random reads from every window, pointer reloaded now and then
    for (int k = 0; k < 40; k++) begin
      if (k % 8 == 0) begin
        rp = (k == 0) ? 2042 : ($random(seed) & 2047);
        au = (k % 16 == 0);
        apb(1, 8'h18, 32'hFFFF_B800 | (au << 14) | rp, 4'hF);
      end
      i = $unsigned($random(seed)) % 5;
      apb(0, wa[i], 0, 0);
      x = 32'h0;
      for (int j = 0; j < ws[i]; j++) x[8*j+:8] = 8'(((rp + j) % 2048) * 7 + 3);
      chk(rd, x);
      if (au) rp = (rp + ws[i]) % 2048;
      apb(0, 8'h18, 0, 0);
      chk(rd, (au << 14) | rp);
    end
    // Release command and pointer reload
    apb(1, 8'h08, 1, 4'hF);
    rd = 1;
    for (int n = 0; n < 20 && rd[0]; n++) apb(0, 8'h08, 0, 0);
    chk(rd, 0);
    apb(0, 8'h18, 0, 0);
    chk(rd, (au << 14) | 11'h123);
    // Transmit writes with the buffer filled and stalled
    tp = 2046;
    apb(1, 8'h10, 32'h4000 | tp, 4'hF);
    stall <= 1'b1;
    fork
      for (int k = 0; k < 8; k++) begin
        i = $unsigned($random(seed)) % 3;
        e = $random(seed);
        apb(1, k[0] ? 8'h28 : 8'h20, e, sm[i]);
        w = '{addr: 11'(tp), strb: sm[i], data: e & {{16{i == 2}}, {8{i != 0}}, 8'hFF}};
        exp_q.push_back(w);
        tp = (tp + ws[i]) % 2048;
      end
      begin
        repeat (25) @(posedge pclk);
        stall <= 1'b0;
      end
    join
    repeat (40) @(posedge pclk);
    chk(i_qdp_qm_model.got.size(), exp_q.size());
    foreach (exp_q[k]) begin
      g = i_qdp_qm_model.got[k];
      g.data = i_qdp_qm_model.got[k].data & {{8{exp_q[k].strb[3]}}, {8{exp_q[k].strb[2]}},
               {8{exp_q[k].strb[1]}}, {8{exp_q[k].strb[0]}}};
      chk(g, exp_q[k]);
    end
    // Enqueue command and transmit pointer reload
    apb(1, 8'h00, 1, 4'hF);
    rd = 1;
    for (int n = 0; n < 20 && rd[0]; n++) apb(0, 8'h00, 0, 0);
    chk(rd, 0);
    apb(0, 8'h10, 0, 0);
    chk(rd, 32'h4000 | 11'h456);
    report_and_stop();
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    report_and_stop();
  end
endmodule  // testbench
`default_nettype wire
